// file: logic/pee_host_pkg.sv
package pee_host_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_LSB = 8;
   localparam int PAGE_BYTES = 256;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int STROBE_NS = 150;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BYTE_GAP_US = 100;
   localparam int BYTE_GAP_CYC = (BYTE_GAP_US * 1000) / CLK_PERIOD_NS;
   localparam int WRITE_MS = 5;
   localparam int WRITE_CYC = (WRITE_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// file: logic/pee_host.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) each access drives one 17-bit address selecting one byte.
// (R2) chip select is low for every access, high when idle.
// (R3) read drives output enable and chip select low, samples data.
// (R4) device ends read when chip select or output enable rises.
// (R5) device floats data while output enable or chip select is high.
// (R6) write: chip select and write strobe low, output enable high.
// (R7) device latches address on later falling strobe edge.
// (R8) device latches data on earlier rising strobe edge.
// (R9) device self-times programming, typically five milliseconds.
// (R10) device accepts up to 256 byte loads per page.
// (R11) host keeps address bits 8..16 fixed during a page load.
// (R12) host starts each next byte within 100 us of previous.
// (R13) device programs page when 100 us pass without a new byte.
// (R14) page load window has no total length limit.
// (R15) any write may start a page; later bytes use same sequence.
// (R16) device reports progress via two status bits on reads.
// (R17) bit 7 reads inverted during programming, true afterwards.
// (R18) bit 6 toggles on each read during programming.
// (R19) write strobe pulses under 10 ns start no write.
// (R20) no write while output enable low or strobes high.
// (R21) device ignores writes during programming.
module pee_host #(
   parameter int GAP_CYC = pee_host_pkg::BYTE_GAP_CYC,
   parameter int WAIT_CYC = 2 * pee_host_pkg::WRITE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic rd_req_i,
   input wire logic wr_req_i,
   input wire logic last_i,
   input wire logic [pee_host_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [pee_host_pkg::DATA_W-1:0] req_data_i,
   output logic busy_o,
   output logic rd_valid_o,
   output logic [pee_host_pkg::DATA_W-1:0] rd_data_o,
   output logic wr_done_o,
   output logic wr_timeout_o,
   output logic [pee_host_pkg::ADDR_W-1:0] addr_bus_o,
   input wire logic [pee_host_pkg::DATA_W-1:0] data_bus_i,
   output logic [pee_host_pkg::DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_n_o,
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic wr_strobe_n_o
);
   // ---------------------------------------------------------------
   // types and state
   // ---------------------------------------------------------------
   typedef enum {IDLE, RD_STROBE, WR_SETUP, WR_STROBE, WR_HOLD,
                 GAP, POLL_STROBE, POLL_CHECK} state_t;
   state_t state, next_state;
   logic [31:0] cnt, next_cnt;
   logic [31:0] wait_cnt, next_wait_cnt;
   logic [8:0] page_cnt, next_page_cnt;
   logic [pee_host_pkg::ADDR_W-1:0] addr, next_addr;
   logic [pee_host_pkg::DATA_W-1:0] wdata, next_wdata;
   logic [pee_host_pkg::DATA_W-1:0] rdata, next_rdata;
   logic busy, next_busy, rd_valid, next_rd_valid;
   logic wr_done, next_wr_done, wr_to, next_wr_to;
   logic cs_n, next_cs_n, oe_n, next_oe_n, we_n, next_we_n;
   logic dr_n, next_dr_n;
   logic [pee_host_pkg::DATA_W-1:0] s1, s2, s3;

   // three-stage pin sampler; stage two and three must agree
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s1 <= 8'h00;
         s2 <= 8'h00;
         s3 <= 8'h00;
      end else if (clk_en_i) begin
         s1 <= data_bus_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   function automatic logic same_page(
      input logic [pee_host_pkg::ADDR_W-1:0] a,
      input logic [pee_host_pkg::ADDR_W-1:0] b);
      same_page = a[pee_host_pkg::ADDR_W-1:pee_host_pkg::PAGE_LSB] ==
                  b[pee_host_pkg::ADDR_W-1:pee_host_pkg::PAGE_LSB];
   endfunction

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_wait_cnt = wait_cnt;
      next_page_cnt = page_cnt;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_busy = 1'b1;
      next_rd_valid = 1'b0;
      next_wr_done = 1'b0;
      next_wr_to = 1'b0;
      next_cs_n = 1'b1;                      // standby when idle [R2]
      next_oe_n = 1'b1;
      next_we_n = 1'b1;
      next_dr_n = 1'b1;
      unique case (state)
         IDLE: begin
            next_busy = 1'b0;
            next_cnt = 32'h0000_0000;
            if (rd_req_i) begin
               next_addr = req_addr_i;         // [R1]
               next_cs_n = 1'b0;               // [R3]
               next_oe_n = 1'b0;
               next_busy = 1'b1;
               next_state = RD_STROBE;
            end else if (wr_req_i) begin
               next_addr = req_addr_i;         // [R1]
               next_wdata = req_data_i;
               next_page_cnt = 9'h001;         // any write opens a page [R15]
               next_busy = 1'b1;
               next_dr_n = 1'b0;
               next_state = WR_SETUP;
            end
         end
         RD_STROBE: begin
            next_cs_n = 1'b0;
            next_oe_n = 1'b0;
            next_cnt = cnt + 32'h1;
            // allow sampler latency on top of access time
            if (cnt >= 32'(pee_host_pkg::STROBE_CYC + 3)) begin
               next_rdata = s3;
               next_rd_valid = (s2 == s3);
               next_cs_n = 1'b1;               // end read [R4]
               next_oe_n = 1'b1;
               next_cnt = 32'h0000_0000;
               next_state = next_rd_valid ? IDLE : RD_STROBE;
               if (!next_rd_valid) begin
                  next_cs_n = 1'b0;
                  next_oe_n = 1'b0;
               end
            end
         end
         WR_SETUP: begin
            // oe high before strobes fall, no contention [R6] [R20]
            next_dr_n = 1'b0;
            next_cs_n = 1'b0;
            next_we_n = 1'b0;                  // addr stable at fall [R7]
            next_cnt = 32'h0000_0000;
            next_state = WR_STROBE;
         end
         WR_STROBE: begin
            next_dr_n = 1'b0;
            next_cs_n = 1'b0;
            next_we_n = 1'b0;
            next_cnt = cnt + 32'h1;
            // pulse well above 10 ns [R19]
            if (cnt >= 32'(pee_host_pkg::STROBE_CYC - 1)) begin
               next_we_n = 1'b1;               // data held past rise [R8]
               next_state = WR_HOLD;
            end
         end
         WR_HOLD: begin
            next_dr_n = 1'b0;
            next_cnt = 32'h0000_0000;
            next_state = GAP;
         end
         GAP: begin
            next_cnt = cnt + 32'h1;
            // next byte must fall inside the 100 us window [R12]
            if (wr_req_i && !last_i && page_cnt < 9'(pee_host_pkg::PAGE_BYTES)
                && same_page(req_addr_i, addr)     // [R11]
                && cnt < 32'(GAP_CYC - 4 * pee_host_pkg::STROBE_CYC)) begin
               next_addr = req_addr_i;
               next_wdata = req_data_i;
               next_page_cnt = page_cnt + 9'h001; // [R10]
               next_dr_n = 1'b0;
               next_state = WR_SETUP;
            end else if (cnt >= 32'(GAP_CYC)) begin
               // device programs once the gap expires [R13]
               // last_i only stops loads: polling early reads stale data
               next_wait_cnt = 32'h0000_0000;
               next_cnt = 32'h0000_0000;
               next_cs_n = 1'b0;               // same timing as a read [R3]
               next_oe_n = 1'b0;
               next_state = POLL_STROBE;
            end
         end
         POLL_STROBE: begin
            next_cs_n = 1'b0;
            next_oe_n = 1'b0;
            next_cnt = cnt + 32'h1;
            next_wait_cnt = wait_cnt + 32'h1;
            if (cnt >= 32'(pee_host_pkg::STROBE_CYC + 3) && s2 == s3) begin
               next_rdata = s3;
               next_cs_n = 1'b1;
               next_oe_n = 1'b1;
               next_cnt = 32'h0000_0000;
               next_state = POLL_CHECK;
            end
         end
         POLL_CHECK: begin
            next_wait_cnt = wait_cnt + 32'h1;
            // true bit 7 means programming done [R16] [R17] [R9]
            if (rdata[pee_host_pkg::POLL_BIT] == wdata[pee_host_pkg::POLL_BIT])
               begin
               next_wr_done = 1'b1;
               next_state = IDLE;
            end else if (wait_cnt >= 32'(WAIT_CYC)) begin
               next_wr_to = 1'b1;
               next_state = IDLE;
            end else begin
               next_cnt = 32'h0000_0000;
               // one high cycle in this state separates two polls
               next_cs_n = 1'b0;
               next_oe_n = 1'b0;
               next_state = POLL_STROBE;        // writes held off meanwhile [R21]
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= IDLE;
         cnt <= 32'h0000_0000;
         wait_cnt <= 32'h0000_0000;
         page_cnt <= 9'h000;
         addr <= 17'h00000;
         wdata <= 8'h00;
         rdata <= 8'h00;
         busy <= 1'b0;
         rd_valid <= 1'b0;
         wr_done <= 1'b0;
         wr_to <= 1'b0;
         cs_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         dr_n <= 1'b1;
      end else if (clk_en_i) begin
         state <= next_state;
         cnt <= next_cnt;
         wait_cnt <= next_wait_cnt;
         page_cnt <= next_page_cnt;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         busy <= next_busy;
         rd_valid <= next_rd_valid;
         wr_done <= next_wr_done;
         wr_to <= next_wr_to;
         cs_n <= next_cs_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         dr_n <= next_dr_n;
      end
   end

   // outputs straight from flops
   assign busy_o = busy;
   assign rd_valid_o = rd_valid;
   assign rd_data_o = rdata;
   assign wr_done_o = wr_done;
   assign wr_timeout_o = wr_to;
   assign addr_bus_o = addr;
   assign data_bus_o = wdata;
   assign data_bus_oe_n_o = dr_n;
   assign chip_sel_n_o = cs_n;
   assign out_en_n_o = oe_n;
   assign wr_strobe_n_o = we_n;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_wr_oe_high;
      @(posedge sys_clk_i) disable iff (rst_i)
      !we_n |-> oe_n && !cs_n;
   endproperty
   a_wr_oe_high: assert property (p_wr_oe_high) // [R6]
      else $error("write strobe low with oe low or cs high");
   property p_no_drive_in_read;
      @(posedge sys_clk_i) disable iff (rst_i)
      !oe_n |-> dr_n;
   endproperty
   a_no_drive_in_read: assert property (p_no_drive_in_read) // [R5]
      else $error("host drives data during read");
   property p_we_width;
      @(posedge sys_clk_i) disable iff (rst_i || !clk_en_i)
      $fell(we_n) |=> !we_n;
   endproperty
   a_we_width: assert property (p_we_width) // [R19]
      else $error("write strobe pulse too short");
   property p_data_hold;
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(we_n) |-> !dr_n;
   endproperty
   a_data_hold: assert property (p_data_hold) // [R8]
      else $error("data released before strobe rise");
   property p_addr_stable;
      @(posedge sys_clk_i) disable iff (rst_i)
      !we_n && !$fell(we_n) |-> $stable(addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) // [R7]
      else $error("address moved during write strobe");
   property p_idle_cs;
      @(posedge sys_clk_i) disable iff (rst_i)
      !busy |-> cs_n;
   endproperty
   a_idle_cs: assert property (p_idle_cs) // [R2]
      else $error("chip select low while idle");
   property p_page_len;
      @(posedge sys_clk_i) disable iff (rst_i)
      page_cnt <= 9'(pee_host_pkg::PAGE_BYTES);
   endproperty
   a_page_len: assert property (p_page_len) // [R10]
      else $error("page longer than allowed");
   property p_same_page;
      @(posedge sys_clk_i) disable iff (rst_i || !clk_en_i)
      state == GAP && next_state == WR_SETUP |=> same_page(addr, $past(addr));
   endproperty
   a_same_page: assert property (p_same_page) // [R11]
      else $error("page address changed during load");
   c_read: cover property (@(posedge sys_clk_i) rd_valid);
   c_write: cover property (@(posedge sys_clk_i) wr_done);
   c_page: cover property (@(posedge sys_clk_i) page_cnt == 9'h002);
endmodule // pee_host

// file: dv/byte_mem_model.sv
`timescale 1ns/1ps
module byte_mem_model #(
   parameter int GAP_NS = 1000,
   parameter int PROG_NS = 5000
) (
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [16:0] addr_i,
   input wire logic [7:0] dq_i,
   input wire logic stuck_i,
   input wire logic [9:0] acc_ns_i,
   output logic [7:0] dq_o,
   output logic dq_en_o,
   output logic viol_o
);
   logic [7:0] mem [int];
   logic [7:0] pg [int];
   logic [16:0] a_lat = 17'h00000;
   logic [7:0] last_d = 8'h00;
   logic [7:0] val;
   logic wr_act = 1'b0;
   logic loading = 1'b0;
   logic prog = 1'b0;
   logic tgl = 1'b0;
   logic rd_ok = 1'b0;
   realtime t_fall = 0.0;
   realtime t_end = 0.0;
   initial viol_o = 1'b0;
   // ---------------------------------------------------------------
   // write side
   // ---------------------------------------------------------------
   // address on the later falling strobe; busy array drops the write
   always @(negedge cs_n_i or negedge we_n_i) begin
      if (!cs_n_i && !we_n_i && oe_n_i) begin
         if (prog) viol_o = 1'b1;
         if (loading && addr_i[16:8] != a_lat[16:8]) viol_o = 1'b1;
         a_lat = addr_i;
         t_fall = $realtime;
         wr_act = !prog;
      end
   end
   // data on the earlier rising strobe; glitches load nothing
   always @(posedge cs_n_i or posedge we_n_i) begin
      if (wr_act && $realtime - t_fall >= 10) begin
         pg[int'(a_lat)] = dq_i;
         last_d = dq_i;
         loading = 1'b1;
      end
      wr_act = 1'b0;
   end
   // byte gap closes the page, then self-timed programming
   always #10 begin
      if (loading && !wr_act && $realtime - t_fall >= GAP_NS) begin
         loading = 1'b0;
         prog = 1'b1;
         t_end = $realtime + PROG_NS;
      end
      if (prog && !stuck_i && $realtime >= t_end) begin
         foreach (pg[k]) mem[k] = pg[k];
         pg.delete();
         prog = 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // read side
   // ---------------------------------------------------------------
   // each read start flips the toggle bit while programming
   always @(negedge oe_n_i or negedge cs_n_i) begin
      if (!oe_n_i && !cs_n_i) begin
         if (prog) tgl = !tgl;
         rd_ok = 1'b0;
         #(acc_ns_i) rd_ok = 1'b1;
      end
   end
   assign dq_en_o = !oe_n_i && !cs_n_i;
   // data is wrong until access time has passed
   always @* begin
      if (prog) val = {~last_d[7], tgl, last_d[5:0]};
      else val = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hff;
      dq_o = rd_ok ? val : ~val;
   end
endmodule // byte_mem_model

// file: dv/pee_host_tb_top.sv
`timescale 1ns/1ps
module pee_host_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic rd_req = 1'b0;
   logic wr_req = 1'b0;
   logic last = 1'b0;
   logic stuck = 1'b0;
   logic clash = 1'b0;
   logic [16:0] req_addr = 17'h00000;
   logic [7:0] req_data = 8'h00;
   logic [9:0] acc_ns = 10'h064;
   logic [7:0] last_bus = 8'h00;
   logic [7:0] data_in, data_out, mdl_q, rd_data;
   logic [16:0] addr_bus;
   logic busy, rd_valid, wr_done, wr_timeout, data_oe_n;
   logic cs_n, oe_n, we_n, mdl_en, viol;
   logic [7:0] shadow [int];
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   pee_host #(.GAP_CYC(40), .WAIT_CYC(400)) DUT (
      .sys_clk_i(clk), .rst_i(rst), .clk_en_i(clk_en),
      .rd_req_i(rd_req), .wr_req_i(wr_req), .last_i(last),
      .req_addr_i(req_addr), .req_data_i(req_data), .busy_o(busy),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .wr_done_o(wr_done),
      .wr_timeout_o(wr_timeout), .addr_bus_o(addr_bus),
      .data_bus_i(data_in), .data_bus_o(data_out),
      .data_bus_oe_n_o(data_oe_n), .chip_sel_n_o(cs_n),
      .out_en_n_o(oe_n), .wr_strobe_n_o(we_n));
   byte_mem_model mem_dev (
      .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr_bus),
      .dq_i(data_out), .stuck_i(stuck), .acc_ns_i(acc_ns),
      .dq_o(mdl_q), .dq_en_o(mdl_en), .viol_o(viol));
   // released bus drifts so a stale byte never looks valid
   assign data_in = !data_oe_n ? data_out : mdl_en ? mdl_q : ~last_bus;
   always #25 clk = ~clk;
   // stall, bus watch and hang limit
   always @(posedge clk) begin
      last_bus <= data_in;
      clk_en <= #1 rst ? 1'b1 : ($urandom_range(7) != 0);
      if (!rst) clash <= clash | (!data_oe_n && mdl_en) | (!we_n && !oe_n);
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fails++;
         report_and_stop();
      end
   end
   function automatic logic [7:0] expect_rd(input logic [16:0] a);
      return shadow.exists(int'(a)) ? shadow[int'(a)] : 8'hff;
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // request held until the strobe of this byte is seen
   task automatic put_byte(input logic [16:0] a, input logic [7:0] d);
      req_addr = a;
      req_data = d;
      wr_req = 1'b1;
      for (int i = 0; i < 500 && we_n !== 1'b1; i++) @(posedge clk) #1;
      for (int i = 0; i < 500 && we_n !== 1'b0; i++) @(posedge clk) #1;
      shadow[int'(a)] = d;
   endtask
   task automatic wait_end(output logic done, output logic tmo);
      done = 1'b0;
      tmo = 1'b0;
      for (int i = 0; i < 2000 && (busy === 1'b1 || i == 0); i++) begin
         @(posedge clk) #1;
         done |= wr_done;
         tmo |= wr_timeout;
      end
   endtask
   task automatic read_byte(input logic [16:0] a, output logic [7:0] d);
      req_addr = a;
      rd_req = 1'b1;
      // a pulse left from the previous read must not pass as this one
      for (int i = 0; i < 500 && rd_valid !== 1'b0; i++) @(posedge clk) #1;
      for (int i = 0; i < 500 && rd_valid !== 1'b1; i++) @(posedge clk) #1;
      rd_req = 1'b0;
      d = rd_data;
   endtask
   // main sequence
   initial begin
      logic done, tmo;
      logic [7:0] d;
      logic [7:0] d2;
      logic [16:0] a;
      void'($urandom(3111));
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      check("cs_n", cs_n, 1'b1);
      check("oe_n", oe_n, 1'b1);
      check("we_n", we_n, 1'b1);
      check("dq_oe_n", data_oe_n, 1'b1);
      check("busy", busy, 1'b0);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($urandom);
         // access time kept within the strobe the host allows for
         acc_ns = 10'($urandom_range(pee_host_pkg::STROBE_NS, 20));
         put_byte(a, 8'($urandom));
         wr_req = 1'b0;
         wait_end(done, tmo);
         check("wr_done", done, 1'b1);
         read_byte(a, d);
         check("rd_data", d, expect_rd(a));
      end
      $display("test byte writes done");
      a = {9'($urandom), 8'h00};
      for (int i = 0; i < 256; i++) put_byte(a + 17'(i), 8'($urandom));
      wr_req = 1'b0;
      last = 1'b1;
      wait_end(done, tmo);
      last = 1'b0;
      check("page_done", done, 1'b1);
      for (int i = 0; i < 256; i += 51) begin
         read_byte(a + 17'(i), d);
         check("page_rd", d, expect_rd(a + 17'(i)));
      end
      $display("test full page done");
      stuck = 1'b1;
      put_byte(a, 8'h5a);
      wr_req = 1'b0;
      wait_end(done, tmo);
      check("timeout", tmo, 1'b1);
      // array still busy: status bits show on plain reads
      read_byte(a, d);
      read_byte(a, d2);
      check("toggle_bit", d[6] ^ d2[6], 1'b1);
      // written 8'h5a has bit 7 clear, so it reads back set
      check("poll_bit", d2[7], 1'b1);
      stuck = 1'b0;
      repeat (20) @(posedge clk);
      #1 read_byte(a, d);
      check("late_rd", d, 8'h5a);
      $display("test stuck programming done");
      check("host_faults", viol, 1'b0);
      check("bus_clash", clash, 1'b0);
      report_and_stop();
   end
endmodule // pee_host_tb_top
